// >>> verilog/gosm_defs.svh
// constants for the general output signal mux: offsets, fields, codes
`ifndef GOSM_DEFS_SVH
`define GOSM_DEFS_SVH

// register bus geometry
`define GOSM_ADDR_W 4
`define GOSM_DATA_W 8

// register offsets
`define GOSM_ADDR_PIN_C_CFG 4'h0
`define GOSM_ADDR_PIN_B_CFG 4'h1
`define GOSM_ADDR_PIN_A_CFG 4'h2
`define GOSM_ADDR_STICKY 4'h3
`define GOSM_ADDR_PIN_STATE 4'h4

// configuration register fields
`define GOSM_CFG_TEMP_BIT 7
`define GOSM_CFG_INV_BIT 6
`define GOSM_CFG_SEL_W 6

// reset values of the configuration registers
`define GOSM_RST_PIN_C_CFG 8'h29
`define GOSM_RST_PIN_B_CFG 8'h2E
`define GOSM_RST_PIN_A_CFG 8'h3F

// select codes
`define GOSM_SEL_RX_THR 6'h00
`define GOSM_SEL_RX_PKT 6'h01
`define GOSM_SEL_TX_THR 6'h02
`define GOSM_SEL_TX_FULL 6'h03
`define GOSM_SEL_RX_OVF 6'h04
`define GOSM_SEL_TX_UNF 6'h05
`define GOSM_SEL_SYNC 6'h06
`define GOSM_SEL_CRC_OK 6'h07
`define GOSM_SEL_PQI 6'h08
`define GOSM_SEL_CCA 6'h09
`define GOSM_SEL_LOCK 6'h0A
`define GOSM_SEL_SER_CLK 6'h0B
`define GOSM_SEL_CARRIER 6'h0E
`define GOSM_SEL_HIZ 6'h2E
`define GOSM_SEL_LOW 6'h2F
`define GOSM_SEL_CLK_DIV 6'h3F

// reference clock divide ratio for the default clock output
`define GOSM_CLK_DIV 192
`define GOSM_DIV_CNT_W 7

`endif

// >>> verilog/gosm_pkg.sv
// types shared by the general output signal mux modules
package gosm_pkg;

    // one pin configuration register
    typedef struct packed {
        logic temp_en;
        logic invert;
        logic [5:0] sel;
    } gosm_cfg_s;

    // register bus request from software
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gosm_bus_s;

    // status levels and one-cycle events from the radio core
    typedef struct packed {
        logic rx_at_thr;
        logic rx_empty;
        logic pkt_end;
        logic tx_at_thr;
        logic tx_full;
        logic rx_overflow;
        logic rx_flush;
        logic tx_underflow;
        logic tx_flush;
        logic sync_word;
        logic addr_fail;
        logic crc_ok_pkt;
        logic rx_first_read;
        logic pqi_above;
        logic cca_clear;
        logic pll_lock;
        logic serial_clk;
        logic carrier_sense;
        logic rx_active;
        logic tx_active;
    } gosm_status_s;

    // flags that hold between their set and clear events
    typedef struct packed {
        logic crc_ok;
        logic sync_active;
        logic tx_unf;
        logic rx_ovf;
        logic tx_full_hold;
        logic rx_pkt;
    } gosm_sticky_s;

endpackage

// >>> verilog/gosm_pin_stage.sv
// one output pin: selects a source, inverts, registers level and enable
`include "gosm_defs.svh"

module gosm_pin_stage
    import gosm_pkg::*;
#(
    parameter logic RESET_OE = 1'b0
) (
    input wire logic i_clk,          // reference clock
    input wire logic i_resetn,       // async reset, active low
    input wire logic [63:0] i_src,   // candidate signals by select code
    input wire gosm_cfg_s i_cfg,     // pin configuration
    input wire logic i_ovr,          // override the mux
    input wire logic i_ovr_val,      // level while overridden
    input wire logic i_ovr_oe,       // enable while overridden
    output logic o_pin,              // registered pin level
    output logic o_oe                // registered output enable
);

    logic pin_reg;
    logic pin_next;
    logic oe_reg;
    logic oe_next;

    // selection is combinational, only the flop reaches the pin
    always_comb begin
        pin_next = i_src[i_cfg.sel] ^ i_cfg.invert;
        oe_next = 1'b1;
        if (i_cfg.sel == `GOSM_SEL_HIZ || i_cfg.temp_en) begin
            oe_next = 1'b0;
        end
        if (i_ovr) begin
            pin_next = i_ovr_val;
            oe_next = i_ovr_oe;
        end
    end

    // registered so a reconfiguration never glitches the pin
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_reg <= 1'b0;
            oe_reg <= RESET_OE;
        end else begin
            pin_reg <= pin_next;
            oe_reg <= oe_next;
        end
    end

    assign o_pin = pin_reg;
    assign o_oe = oe_reg;

endmodule

// >>> verilog/gosm_top.sv
// general output signal mux: config registers, event flags, three pins
//
// How it works
// - each pin has its own six-bit select
// - pin b carries serial data while selected
// - pin b is high impedance after reset
// - pin a outputs reference clock over 192
// - writing 128 to pin a enables temperature
// - code 0 follows rx fill threshold level
// - code 1 set threshold/packet end, clear empty
// - code 2 follows tx fill threshold level
// - code 3 set full, clear below threshold
// - code 4 holds rx overflow until flush
// - code 5 holds tx underflow until flush
// - code 6 sync to packet end or abort
// - code 7 crc ok until first read
// - code 8 preamble quality above threshold
// - code 9 clear channel assessment level
// - code 10 shows synthesizer lock detector
// - code 11 shows serial bit clock
// - code 47 drives low, invert gives high
// - code 14 shows carrier sense
`include "gosm_defs.svh"

module gosm_top
    import gosm_pkg::*;
#(
    parameter int DIV_RATIO = `GOSM_CLK_DIV
) (
    input wire logic i_clk,              // reference oscillator clock
    input wire logic i_resetn,           // async reset, active low
    input wire gosm_bus_s i_bus,         // register bus request
    output logic [7:0] o_rdata,          // read data, cycle after read
    input wire gosm_status_s i_status,   // radio core status and events
    input wire logic i_chip_select_n,    // serial interface select, low
    input wire logic i_spi_so,           // serial data out from spi
    input wire logic i_spi_so_oe,        // spi drives its data out
    output logic o_gen_out_pin_a,        // pin a level
    output logic o_gen_out_pin_a_oe,     // pin a output enable
    output logic o_gen_out_pin_b,        // pin b level
    output logic o_gen_out_pin_b_oe,     // pin b output enable
    output logic o_gen_out_pin_c,        // pin c level
    output logic o_gen_out_pin_c_oe,     // pin c output enable
    output logic o_temp_sense_en         // pin a carries analog sensor
);

    localparam int HALF = DIV_RATIO / 2;
    localparam logic [6:0] HALF_LAST = 7'(HALF - 1);

    // ---- configuration registers ----
    gosm_cfg_s pin_a_config_reg;
    gosm_cfg_s pin_a_config_next;
    gosm_cfg_s pin_b_config_reg;
    gosm_cfg_s pin_b_config_next;
    gosm_cfg_s pin_c_config_reg;
    gosm_cfg_s pin_c_config_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // ---- event flags ----
    gosm_sticky_s sticky_reg;
    gosm_sticky_s sticky_next;

    // ---- clock divider ----
    logic [`GOSM_DIV_CNT_W-1:0] div_cnt_reg;
    logic [`GOSM_DIV_CNT_W-1:0] div_cnt_next;
    logic div_clk_reg;
    logic div_clk_next;
    logic temp_en_reg;
    logic temp_en_next;

    // ---- mux sources and pin wires ----
    logic [63:0] src;
    logic pin_a;
    logic pin_a_oe;
    logic pin_b;
    logic pin_b_oe;
    logic pin_c;
    logic pin_c_oe;

    // pin b and c have no analog path, so their top bit is kept zero
    function automatic gosm_cfg_s cfg_digital(input logic [7:0] d);
        gosm_cfg_s c;
        c = gosm_cfg_s'(d);
        c.temp_en = 1'b0;
        return c;
    endfunction

    // register writes; one-cycle strobe with address and data
    always_comb begin
        pin_a_config_next = pin_a_config_reg;
        pin_b_config_next = pin_b_config_reg;
        pin_c_config_next = pin_c_config_reg;
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                `GOSM_ADDR_PIN_A_CFG: begin
                    pin_a_config_next = gosm_cfg_s'(i_bus.wdata);
                end
                `GOSM_ADDR_PIN_B_CFG: begin
                    pin_b_config_next = cfg_digital(i_bus.wdata);
                end
                `GOSM_ADDR_PIN_C_CFG: begin
                    pin_c_config_next = cfg_digital(i_bus.wdata);
                end
                default: begin
                    // read-only and unmapped offsets ignore writes
                end
            endcase
        end
    end

    // read data stands only in the cycle after the read strobe
    always_comb begin
        rdata_next = 8'h00;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                `GOSM_ADDR_PIN_A_CFG: rdata_next = pin_a_config_reg;
                `GOSM_ADDR_PIN_B_CFG: rdata_next = pin_b_config_reg;
                `GOSM_ADDR_PIN_C_CFG: rdata_next = pin_c_config_reg;
                `GOSM_ADDR_STICKY: rdata_next = {2'b00, sticky_reg};
                `GOSM_ADDR_PIN_STATE: begin
                    rdata_next = {2'b00, pin_c_oe, pin_b_oe, pin_a_oe,
                        pin_c, pin_b, pin_a};
                end
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // pins restart from their power-on selections
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_a_config_reg <= `GOSM_RST_PIN_A_CFG;
            pin_b_config_reg <= `GOSM_RST_PIN_B_CFG;
            pin_c_config_reg <= `GOSM_RST_PIN_C_CFG;
            rdata_reg <= 8'h00;
        end else begin
            pin_a_config_reg <= pin_a_config_next;
            pin_b_config_reg <= pin_b_config_next;
            pin_c_config_reg <= pin_c_config_next;
            rdata_reg <= rdata_next;
        end
    end

    // event flags; in every flag a set in the clear cycle wins
    always_comb begin
        sticky_next = sticky_reg;
        // fill threshold or packet end, held until the fifo is empty
        if (i_status.rx_empty) begin
            sticky_next.rx_pkt = 1'b0;
        end
        if (i_status.rx_at_thr || i_status.pkt_end) begin
            sticky_next.rx_pkt = 1'b1;
        end
        // full is held until the fifo drains below its threshold
        if (!i_status.tx_at_thr) begin
            sticky_next.tx_full_hold = 1'b0;
        end
        if (i_status.tx_full) begin
            sticky_next.tx_full_hold = 1'b1;
        end
        // overflow survives until software flushes the fifo
        if (i_status.rx_flush) begin
            sticky_next.rx_ovf = 1'b0;
        end
        if (i_status.rx_overflow) begin
            sticky_next.rx_ovf = 1'b1;
        end
        if (i_status.tx_flush) begin
            sticky_next.tx_unf = 1'b0;
        end
        if (i_status.tx_underflow) begin
            sticky_next.tx_unf = 1'b1;
        end
        // sync to packet end, cut short by the direction's abort
        if (i_status.pkt_end
            || (i_status.rx_active
                && (i_status.addr_fail || i_status.rx_overflow))
            || (i_status.tx_active && i_status.tx_underflow)) begin
            sticky_next.sync_active = 1'b0;
        end
        if (i_status.sync_word) begin
            sticky_next.sync_active = 1'b1;
        end
        // good packet flag, dropped as soon as its first byte is read
        if (i_status.rx_first_read) begin
            sticky_next.crc_ok = 1'b0;
        end
        if (i_status.crc_ok_pkt) begin
            sticky_next.crc_ok = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sticky_reg <= '0;
        end else begin
            sticky_reg <= sticky_next;
        end
    end

    // divider toggles every half ratio so the output is square
    always_comb begin
        div_cnt_next = div_cnt_reg + 7'h01;
        div_clk_next = div_clk_reg;
        if (div_cnt_reg == HALF_LAST) begin
            div_cnt_next = 7'h00;
            div_clk_next = ~div_clk_reg;
        end
        temp_en_next = pin_a_config_reg.temp_en;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_cnt_reg <= 7'h00;
            div_clk_reg <= 1'b0;
            temp_en_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            div_clk_reg <= div_clk_next;
            temp_en_reg <= temp_en_next;
        end
    end

    // source table indexed by select code; unlisted codes read low
    always_comb begin
        src = 64'h0000_0000_0000_0000;
        src[`GOSM_SEL_RX_THR] = i_status.rx_at_thr;
        src[`GOSM_SEL_RX_PKT] = sticky_reg.rx_pkt;
        src[`GOSM_SEL_TX_THR] = i_status.tx_at_thr;
        src[`GOSM_SEL_TX_FULL] = sticky_reg.tx_full_hold;
        src[`GOSM_SEL_RX_OVF] = sticky_reg.rx_ovf;
        src[`GOSM_SEL_TX_UNF] = sticky_reg.tx_unf;
        src[`GOSM_SEL_SYNC] = sticky_reg.sync_active;
        src[`GOSM_SEL_CRC_OK] = sticky_reg.crc_ok;
        src[`GOSM_SEL_PQI] = i_status.pqi_above;
        src[`GOSM_SEL_CCA] = i_status.cca_clear;
        src[`GOSM_SEL_LOCK] = i_status.pll_lock;
        src[`GOSM_SEL_SER_CLK] = i_status.serial_clk;
        src[`GOSM_SEL_CARRIER] = i_status.carrier_sense;
        src[`GOSM_SEL_LOW] = 1'b0;
        src[`GOSM_SEL_CLK_DIV] = div_clk_reg;
    end

    // pin a: drives from reset since it clocks the host
    gosm_pin_stage #(
        .RESET_OE(1'b1)
    ) u_pin_a (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_src(src),
        .i_cfg(pin_a_config_reg),
        .i_ovr(1'b0),
        .i_ovr_val(1'b0),
        .i_ovr_oe(1'b0),
        .o_pin(pin_a),
        .o_oe(pin_a_oe)
    );

    // pin b: serial interface owns it while chip select is low,
    // so the mux level is only meaningful with chip select high
    gosm_pin_stage #(
        .RESET_OE(1'b0)
    ) u_pin_b (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_src(src),
        .i_cfg(pin_b_config_reg),
        .i_ovr(~i_chip_select_n),
        .i_ovr_val(i_spi_so),
        .i_ovr_oe(i_spi_so_oe),
        .o_pin(pin_b),
        .o_oe(pin_b_oe)
    );

    // pin c: plain digital monitor
    gosm_pin_stage #(
        .RESET_OE(1'b1)
    ) u_pin_c (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_src(src),
        .i_cfg(pin_c_config_reg),
        .i_ovr(1'b0),
        .i_ovr_val(1'b0),
        .i_ovr_oe(1'b0),
        .o_pin(pin_c),
        .o_oe(pin_c_oe)
    );

    // outputs come straight from the stage and local flops
    assign o_gen_out_pin_a = pin_a;
    assign o_gen_out_pin_a_oe = pin_a_oe;
    assign o_gen_out_pin_b = pin_b;
    assign o_gen_out_pin_b_oe = pin_b_oe;
    assign o_gen_out_pin_c = pin_c;
    assign o_gen_out_pin_c_oe = pin_c_oe;
    assign o_temp_sense_en = temp_en_reg;
    assign o_rdata = rdata_reg;

endmodule

// >>> dv/gosm_top_sva.sv
// checker: port-level assertions for the general output signal mux
`include "gosm_defs.svh"
module gosm_top_sva
    import gosm_pkg::*;
#(
    parameter int DIV_RATIO = `GOSM_CLK_DIV
) (
    input wire logic i_clk, // clock
    input wire logic i_resetn, // reset, low
    input wire gosm_bus_s i_bus, // bus request
    input wire logic [7:0] o_rdata, // read data
    input wire gosm_status_s i_status, // core status
    input wire logic i_chip_select_n, // select, low
    input wire logic i_spi_so, // serial data
    input wire logic i_spi_so_oe, // serial enable
    input wire logic o_gen_out_pin_a, // pin a
    input wire logic o_gen_out_pin_a_oe, // pin a enable
    input wire logic o_gen_out_pin_b, // pin b
    input wire logic o_gen_out_pin_b_oe, // pin b enable
    input wire logic o_gen_out_pin_c, // pin c
    input wire logic o_gen_out_pin_c_oe, // pin c enable
    input wire logic o_temp_sense_en // analog on pin a
);
    timeunit 1ns;
    timeprecision 1ns;
    gosm_cfg_s cfg_a_reg;
    gosm_cfg_s cfg_b_reg;
    gosm_cfg_s cfg_c_reg;
    logic [1:0] exp_a;
    logic [1:0] exp_c;
    logic ovf_c;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // {known, level} for codes that pass a status level straight through
    function automatic logic [1:0] lvl(gosm_cfg_s c, gosm_status_s s);
        logic v;
        case (c.sel)
            `GOSM_SEL_RX_THR: v = s.rx_at_thr;
            `GOSM_SEL_TX_THR: v = s.tx_at_thr;
            `GOSM_SEL_PQI: v = s.pqi_above;
            `GOSM_SEL_CCA: v = s.cca_clear;
            `GOSM_SEL_LOCK: v = s.pll_lock;
            `GOSM_SEL_SER_CLK: v = s.serial_clk;
            `GOSM_SEL_CARRIER: v = s.carrier_sense;
            `GOSM_SEL_LOW: v = 1'b0;
            default: return 2'b00;
        endcase
        return {1'b1, v ^ c.invert};
    endfunction
    // shadow of config writes; b and c never keep bit 7
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_a_reg <= `GOSM_RST_PIN_A_CFG;
            cfg_b_reg <= `GOSM_RST_PIN_B_CFG;
            cfg_c_reg <= `GOSM_RST_PIN_C_CFG;
        end else if (i_bus.wr) begin
            case (i_bus.addr)
                `GOSM_ADDR_PIN_A_CFG: cfg_a_reg <= i_bus.wdata;
                `GOSM_ADDR_PIN_B_CFG: cfg_b_reg <= {1'b0, i_bus.wdata[6:0]};
                `GOSM_ADDR_PIN_C_CFG: cfg_c_reg <= {1'b0, i_bus.wdata[6:0]};
                default: ;
            endcase
        end
    end
    // expected levels and the overflow selection on pin c
    assign exp_a = lvl(cfg_a_reg, i_status);
    assign exp_c = lvl(cfg_c_reg, i_status);
    assign ovf_c = cfg_c_reg.sel == `GOSM_SEL_RX_OVF;
    sequence s_ovf_set;
        i_status.rx_overflow && ovf_c ##1 ovf_c;
    endsequence
    sequence s_ovf_clr;
        i_status.rx_flush && !i_status.rx_overflow && ovf_c ##1 ovf_c;
    endsequence
    a_level_pin_c: assert property (exp_c[1] |=>
        o_gen_out_pin_c == $past(exp_c[0]))
        else $error("pin c does not follow its source");
    a_level_pin_a: assert property (exp_a[1] && !cfg_a_reg.temp_en |=>
        o_gen_out_pin_a == $past(exp_a[0]))
        else $error("pin a does not follow its source");
    a_reset_enables: assert property ($rose(i_resetn) |->
        o_gen_out_pin_a_oe && !o_gen_out_pin_b_oe && !o_temp_sense_en)
        else $error("wrong pin enables after reset");
    a_pin_b_hiz: assert property (cfg_b_reg.sel == `GOSM_SEL_HIZ &&
        i_chip_select_n |=> !o_gen_out_pin_b_oe)
        else $error("pin b driven while high impedance");
    a_pin_b_serial: assert property (!i_chip_select_n |=>
        o_gen_out_pin_b == $past(i_spi_so) &&
        o_gen_out_pin_b_oe == $past(i_spi_so_oe))
        else $error("pin b does not carry serial data");
    a_ovf_set: assert property (s_ovf_set |=>
        o_gen_out_pin_c == !cfg_c_reg.invert)
        else $error("overflow flag not shown");
    a_ovf_flush: assert property (s_ovf_clr |=>
        o_gen_out_pin_c == cfg_c_reg.invert)
        else $error("overflow flag not cleared by flush");
    a_temp_mode: assert property (cfg_a_reg.temp_en |=>
        o_temp_sense_en && !o_gen_out_pin_a_oe)
        else $error("temperature mode not entered");
    a_read_cfg: assert property (i_bus.rd &&
        i_bus.addr == `GOSM_ADDR_PIN_C_CFG |=> o_rdata == $past(cfg_c_reg))
        else $error("pin c config reads back wrong");
    a_read_idle: assert property (!i_bus.rd |=> o_rdata == 8'h00)
        else $error("read data outside the read cycle");
endmodule
bind gosm_top gosm_top_sva #(.DIV_RATIO(DIV_RATIO)) i_sva (.*);

// >>> dv/gosm_host_model.sv
// host model: samples the mux pins as a microcontroller would
module gosm_host_model (
    input wire logic i_clk, // clock
    input wire logic i_pin_a, // clock pin
    input wire logic i_pin_b, // shared data pin
    input wire logic i_pin_b_oe, // pin b driven
    input wire logic i_pin_c, // interrupt pin
    input wire logic i_chip_select_n, // serial select
    output int o_period, // cycles between rises of a
    output logic o_b_seen, // pin b taken with select high
    output int o_rises // rises seen on c
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_a = 1'b0;
    logic last_c = 1'b0;
    logic drv_b = 1'b0;
    int cnt = 0;
    // a released line shows the inverse of its last level, not a fixed 0
    wire logic b_wire = i_pin_b_oe ? i_pin_b : ~drv_b;
    initial o_rises = 0;
    // sample everything on the host's own clock edge
    always @(posedge i_clk) begin
        if (i_pin_b_oe) drv_b <= i_pin_b;
        if (i_chip_select_n) o_b_seen <= b_wire;
        if (i_pin_a && !last_a) begin
            o_period <= cnt;
            cnt <= 1;
        end else begin
            cnt <= cnt + 1;
        end
        if (i_pin_c && !last_c) o_rises <= o_rises + 1;
        last_a <= i_pin_a;
        last_c <= i_pin_c;
    end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the general output signal mux
`include "gosm_defs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import gosm_pkg::*;
    localparam int DIV = 4;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    gosm_bus_s i_bus = '0;
    gosm_status_s i_status = '0;
    logic i_chip_select_n = 1'b1;
    logic i_spi_so = 1'b0;
    logic i_spi_so_oe = 1'b0;
    logic [7:0] o_rdata;
    logic o_gen_out_pin_a, o_gen_out_pin_a_oe, o_gen_out_pin_b;
    logic o_gen_out_pin_b_oe, o_gen_out_pin_c, o_gen_out_pin_c_oe;
    logic o_temp_sense_en, b_seen;
    int period, rises, miscompares = 0, total_checks = 0, cycles = 0;
    gosm_top #(.DIV_RATIO(DIV)) i_dut (.*);
    gosm_host_model i_host (
        .i_clk(i_clk),
        .i_pin_a(o_gen_out_pin_a),
        .i_pin_b(o_gen_out_pin_b),
        .i_pin_b_oe(o_gen_out_pin_b_oe),
        .i_pin_c(o_gen_out_pin_c),
        .i_chip_select_n(i_chip_select_n),
        .o_period(period),
        .o_b_seen(b_seen),
        .o_rises(rises)
    );
    always #25 i_clk = ~i_clk;
    // a hang counts as a mismatch
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic settle();
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        #1;
        chk(o_rdata, exp);
    endtask
    // reset values, bit 7 of pin c dropped, writes to flags ignored
    task automatic t_reset();
        chk1(o_gen_out_pin_b_oe, 1'b0);
        chk1(o_gen_out_pin_c_oe, 1'b1);
        rd(`GOSM_ADDR_PIN_B_CFG, `GOSM_RST_PIN_B_CFG);
        rd(`GOSM_ADDR_PIN_A_CFG, `GOSM_RST_PIN_A_CFG);
        rd(`GOSM_ADDR_PIN_C_CFG, `GOSM_RST_PIN_C_CFG);
        wr(`GOSM_ADDR_PIN_C_CFG, 8'hFF);
        rd(`GOSM_ADDR_PIN_C_CFG, 8'h7F);
        wr(`GOSM_ADDR_STICKY, 8'hFF);
        rd(`GOSM_ADDR_STICKY, 8'h00);
        rd(4'hF, 8'h00);
        repeat (3 * DIV) @(posedge i_clk);
        chk(8'(period), 8'(DIV));
    endtask
    // each event flag: set pulse, held while idle, then clear pulse
    task automatic t_flags();
        logic [5:0] c;
        gosm_status_s s, h, e;
        for (int k = 0; k < 8; k++) begin
            case (k)
                0: {c, s, h, e} = {6'h01, 20'h20000, 20'h0, 20'h40000};
                1: {c, s, h, e} = {6'h03, 20'h18000, 20'h10000, 20'h0};
                2: {c, s, h, e} = {6'h04, 20'h04000, 20'h0, 20'h02000};
                3: {c, s, h, e} = {6'h05, 20'h01000, 20'h0, 20'h00800};
                4: {c, s, h, e} = {6'h06, 20'h00400, 20'h0, 20'h20000};
                5: {c, s, h, e} = {6'h06, 20'h00402, 20'h2, 20'h00202};
                6: {c, s, h, e} = {6'h06, 20'h00401, 20'h1, 20'h01001};
                default: {c, s, h, e} = {6'h07, 20'h100, 20'h0, 20'h80};
            endcase
            wr(`GOSM_ADDR_PIN_C_CFG, {2'b00, c});
            settle();
            chk1(o_gen_out_pin_c, 1'b0);
            @(posedge i_clk);
            i_status <= s;
            @(posedge i_clk);
            i_status <= h;
            repeat (2) settle();
            chk1(o_gen_out_pin_c, 1'b1);
            @(posedge i_clk);
            i_status <= e;
            @(posedge i_clk);
            i_status <= '0;
            settle();
            chk1(o_gen_out_pin_c, 1'b0);
        end
    endtask
    // level codes on pins c and a at once, opposite inversion on each
    task automatic t_levels();
        logic [5:0] c;
        gosm_status_s v;
        int r0;
        for (int k = 0; k < 8; k++) begin
            case (k)
                0: {c, v} = {6'h00, 20'h80000};
                1: {c, v} = {6'h02, 20'h10000};
                2: {c, v} = {6'h08, 20'h00040};
                3: {c, v} = {6'h09, 20'h00020};
                4: {c, v} = {6'h0A, 20'h00010};
                5: {c, v} = {6'h0B, 20'h00008};
                6: {c, v} = {6'h0E, 20'h00004};
                default: {c, v} = {6'h2F, 20'h0};
            endcase
            for (int i = 0; i < 2; i++) begin
                wr(`GOSM_ADDR_PIN_C_CFG, {1'b0, i[0], c});
                wr(`GOSM_ADDR_PIN_A_CFG, {1'b0, !i[0], c});
                i_status <= v;
                r0 = rises;
                settle();
                chk1(o_gen_out_pin_c, (v != '0) ^ i[0]);
                chk1(o_gen_out_pin_a, (v != '0) ^ !i[0]);
                // the host must see exactly one rise when lock arrives
                if (c == `GOSM_SEL_LOCK && !i[0]) begin
                    chk(8'(rises - r0), 8'h01);
                end
                @(posedge i_clk);
                i_status <= '0;
                settle();
                chk1(o_gen_out_pin_c, i[0]);
            end
        end
    endtask
    // serial data on pin b while selected, then back to high impedance
    task automatic t_spi();
        logic last;
        for (int i = 0; i < 5; i++) begin
            @(posedge i_clk);
            i_chip_select_n <= 1'b0;
            i_spi_so <= i[0];
            i_spi_so_oe <= 1'b1;
            #1;
            if (i > 0) chk1(o_gen_out_pin_b, last);
            last = i[0];
        end
        @(posedge i_clk);
        i_chip_select_n <= 1'b1;
        i_spi_so_oe <= 1'b0;
        settle();
        chk1(o_gen_out_pin_b_oe, 1'b0);
        wr(`GOSM_ADDR_PIN_B_CFG, {2'b01, `GOSM_SEL_LOW});
        settle();
        chk1(b_seen, 1'b1);
        // all three driven: a low, b and c high through inversion
        rd(`GOSM_ADDR_PIN_STATE, 8'h3E);
    endtask
    // analog temperature mode on pin a and back to the clock
    task automatic t_temp();
        wr(`GOSM_ADDR_PIN_A_CFG, 8'h80);
        settle();
        chk1(o_temp_sense_en, 1'b1);
        chk1(o_gen_out_pin_a_oe, 1'b0);
        rd(`GOSM_ADDR_PIN_A_CFG, 8'h80);
        wr(`GOSM_ADDR_PIN_A_CFG, `GOSM_RST_PIN_A_CFG);
        settle();
        chk1(o_temp_sense_en, 1'b0);
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        t_reset();
        t_flags();
        t_levels();
        t_spi();
        t_temp();
        end_sim();
    end
endmodule
